// ==== pkg/scs_consts.svh ====
// Constants for the SMBus configuration slave: offsets, field bits, resets, timing.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define SCS_OFF_STATUS    8'h00
`define SCS_OFF_CUR_SELF  8'h0d
`define SCS_OFF_CUR_BUS   8'h0e
`define SCS_OFF_PON_TIME  8'h0f

// -----------------------------------------------------------------
// Status/command bits and reset values
// -----------------------------------------------------------------
`define SCS_BIT_ATTACH    0
`define SCS_BIT_WPROT     1
`define SCS_BIT_SRESET    2
`define SCS_RST_STATUS    8'h00
`define SCS_RST_CUR_SELF  8'h32
`define SCS_RST_CUR_BUS   8'h32
`define SCS_RST_PON_TIME  8'h32

// -----------------------------------------------------------------
// Mode straps and bus constants
// -----------------------------------------------------------------
`define SCS_SEL_SMBUS     2'b11
`define SCS_GEN_CALL      7'h00

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define SCS_CLK_HZ        10000000
`define SCS_PON_STEP_MS   2
`define SCS_PON_STEP_CYC  (`SCS_PON_STEP_MS * `SCS_CLK_HZ / 1000)

`endif

// ==== pkg/scs_pkg.sv ====
// Types for the SMBus configuration slave.
// Assumes scs_consts.svh on the include path.
`include "scs_consts.svh"

package scs_pkg;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_RECV   = 6'b000010,
        ST_ACK    = 6'b000100,
        ST_SEND   = 6'b001000,
        ST_MACK   = 6'b010000,
        ST_IGNORE = 6'b100000
    } scs_state_e;

    typedef enum logic [1:0] {
        PH_ADDR  = 2'h0,
        PH_REG   = 2'h1,
        PH_DATA  = 2'h2,
        PH_EXTRA = 2'h3
    } scs_phase_e;

    typedef struct packed {
        logic [7:0] curSelf;
        logic [7:0] curBus;
        logic [7:0] ponTime;
    } scs_cfg_s;

endpackage

// ==== rtl/scs_smbus_config_slave.sv ====
// SMBus target that loads the hub configuration bytes and releases USB attach.
// Assumes open-drain wiring outside; bus engine runs on lclk, outputs on clk.
//
// Overview of operation
// - SMBus strap code disables EEPROM loading; configuration comes only over SMBus.
// - In SMBus mode wait indefinitely; signal USB connect only after load finishes.
// - Target only, never initiates; supports just byte write and byte read.
// - Seven-bit target address, eight-bit register index, eight-bit data.
// - Every byte is shifted most significant bit first.
// - Read: index write, repeated START, address read, one byte, host NACK, STOP.
// - Drive data line only in acknowledge slots and returned read data.
// - Exactly one data byte per transaction; no block transfers.
// - Registers change only after a complete well-formed write; malformed leaves them.
// - Acknowledge only the strapped target address.
// - Wrong address or protocol: no acknowledge, engine back to idle.
// - Only defined configuration registers are reachable; others are refused.
// - Self-powered controller current in 2 mA units, default 50.
// - Bus-powered controller current in 2 mA units, default 50.
// - Power-on time byte gives 2 ms steps until port power is good.
// - Writing attach signals USB attach; write-once.
// - START immediately followed by STOP resets the port to idle.
// - Tolerate clock stretching by others; never drive the clock line.
// - Never acknowledge the general call address.
`timescale 1ns/1ps
`include "scs_consts.svh"

module scs_smbus_config_slave
    import scs_pkg::*;
#(
    parameter int PON_STEP_CYCLES = `SCS_PON_STEP_CYC
) (
    input  wire logic       clk,            // System clock
    input  wire logic       srst,           // Sync reset, active high
    input  wire logic       lclk,           // Link sampling clock
    input  wire logic       smbClkIn,       // SMBus clock pin level
    input  wire logic       smbDataIn,      // SMBus data pin level
    output logic            smbDataOut,     // SMBus data drive value
    output logic            smbDataOe,      // SMBus data drive enable
    input  wire logic [6:0] addrStrap,      // Strapped target address
    input  wire logic       config_select_hi, // Mode strap high
    input  wire logic       config_select_lo, // Mode strap low
    output logic            eepromEnable,   // EEPROM loader allowed
    output logic            usbConnect,     // Signal upstream attach
    output scs_cfg_s        cfg,            // Loaded configuration bytes
    input  wire logic       portPowerOn,    // Host port power-on level
    output logic            portPowerGood   // Port power treated as good
);

    // -----------------------------------------------------------------
    // Link domain: reset and pin synchronisers
    // -----------------------------------------------------------------
    logic       lrstS1, lrst;
    logic       sclS1, sclS2, sclD, sdaS1, sdaS2, sdaD;
    logic [1:0] selLS1, selLS2;
    logic [6:0] addrS1, addrS2;

    always_ff @(posedge lclk) begin
        lrstS1 <= srst;
        lrst   <= lrstS1;
        sclS1  <= smbClkIn;
        sclS2  <= sclS1;
        sclD   <= sclS2;
        sdaS1  <= smbDataIn;
        sdaS2  <= sdaS1;
        sdaD   <= sdaS2;
        selLS1 <= {config_select_hi, config_select_lo};
        selLS2 <= selLS1;
        addrS1 <= addrStrap;
        addrS2 <= addrS1;
    end

    wire sclRise   = sclS2 & ~sclD;
    wire sclFall   = ~sclS2 & sclD;
    wire startCond = sclS2 & sclD & sdaD & ~sdaS2;
    wire stopCond  = sclS2 & sclD & ~sdaD & sdaS2;
    wire smbModeL  = (selLS2 == `SCS_SEL_SMBUS);

    // -----------------------------------------------------------------
    // Link domain: engine state and registers
    // -----------------------------------------------------------------
    scs_state_e state;
    scs_phase_e phase;
    logic [3:0] bitCnt;
    logic [7:0] shift, txShift, regIdx, wrData;
    logic       ackNext, sendMode, rptStart, gotReg, wrPend;
    logic [7:0] statusReg;
    scs_cfg_s   cfgL;

    // Register indices that answer on the bus
    function automatic logic isDefined(input logic [7:0] idx);
        isDefined = (idx == `SCS_OFF_STATUS) || (idx == `SCS_OFF_CUR_SELF) ||
                    (idx == `SCS_OFF_CUR_BUS) || (idx == `SCS_OFF_PON_TIME);
    endfunction

    wire       attachedL = statusReg[`SCS_BIT_ATTACH];
    wire       wprot     = statusReg[`SCS_BIT_WPROT];
    wire [7:0] rxByte    = {shift[6:0], sdaS2};
    wire       addrHit   = smbModeL && !attachedL && (rxByte[7:1] == addrS2) &&
                           (rxByte[7:1] != `SCS_GEN_CALL);
    wire       ackAddr   = addrHit && (rptStart ? (gotReg && rxByte[0]) : !rxByte[0]);
    wire       ackReg    = isDefined(rxByte);
    wire       byteDone  = sclRise && (bitCnt == 4'h7);
    wire       ackNow    = (phase == PH_ADDR) ? ackAddr :
                           (phase == PH_REG)  ? ackReg  :
                           (phase == PH_DATA);
    wire [7:0] rdValue   = (regIdx == `SCS_OFF_CUR_SELF) ? cfgL.curSelf :
                           (regIdx == `SCS_OFF_CUR_BUS)  ? cfgL.curBus  :
                           (regIdx == `SCS_OFF_PON_TIME) ? cfgL.ponTime : statusReg;
    wire       commit    = stopCond && wrPend;
    wire       wrStatus  = commit && (regIdx == `SCS_OFF_STATUS);
    wire       wrCfg     = commit && !wprot && (regIdx != `SCS_OFF_STATUS);
    wire       softRst   = wrStatus && wrData[`SCS_BIT_SRESET];
    wire       driveNow  = (state == ST_ACK) || ((state == ST_SEND) && !txShift[7]);

    // Engine sequencing; STOP always returns to idle
    always_ff @(posedge lclk) begin
        if (lrst) begin
            state    <= ST_IDLE;
            phase    <= PH_ADDR;
            bitCnt   <= 4'h0;
            shift    <= 8'h00;
            txShift  <= 8'h00;
            regIdx   <= 8'h00;
            wrData   <= 8'h00;
            ackNext  <= 1'b0;
            sendMode <= 1'b0;
            rptStart <= 1'b0;
            gotReg   <= 1'b0;
            wrPend   <= 1'b0;
        end else if (stopCond || attachedL || !smbModeL) begin
            state  <= ST_IDLE;
            wrPend <= 1'b0;
        end else if (startCond) begin
            state    <= ST_RECV;
            phase    <= PH_ADDR;
            bitCnt   <= 4'h0;
            rptStart <= (state != ST_IDLE);
            gotReg   <= (state != ST_IDLE) && gotReg;
            wrPend   <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE, ST_IGNORE: begin
                end
                ST_RECV: begin
                    if (sclRise) begin
                        shift  <= rxByte;
                        bitCnt <= bitCnt + 4'h1;
                    end
                    if (byteDone) begin
                        ackNext <= ackNow;
                        if (phase == PH_ADDR) begin
                            sendMode <= rxByte[0];
                        end
                        if (phase == PH_REG) begin
                            regIdx <= rxByte;
                            gotReg <= ackReg;
                        end
                        if (phase == PH_DATA) begin
                            wrData <= rxByte;
                            wrPend <= 1'b1;
                        end
                        if (phase == PH_EXTRA) begin
                            wrPend <= 1'b0;
                        end
                    end
                    // Refused byte drops to idle, so a later START is a fresh one
                    if (sclFall && bitCnt == 4'h8) begin
                        state <= ackNext ? ST_ACK : ST_IDLE;
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        bitCnt <= 4'h0;
                        if (sendMode) begin
                            state   <= ST_SEND;
                            txShift <= rdValue;
                        end else begin
                            state <= ST_RECV;
                            phase <= scs_phase_e'(phase + 2'h1);
                        end
                    end
                end
                ST_SEND: begin
                    if (sclFall) begin
                        if (bitCnt == 4'h7) begin
                            state <= ST_MACK;
                        end else begin
                            txShift <= {txShift[6:0], 1'b0};
                            bitCnt  <= bitCnt + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (sclRise) begin
                        state <= ST_IGNORE;
                    end
                end
            endcase
        end
    end

    // Configuration store; written only on a completed write
    always_ff @(posedge lclk) begin
        if (lrst) begin
            statusReg <= `SCS_RST_STATUS;
            cfgL      <= '{curSelf: `SCS_RST_CUR_SELF, curBus: `SCS_RST_CUR_BUS,
                           ponTime: `SCS_RST_PON_TIME};
        end else begin
            if (wrStatus) begin
                statusReg[`SCS_BIT_ATTACH] <= attachedL | wrData[`SCS_BIT_ATTACH];
                statusReg[`SCS_BIT_WPROT]  <= wprot | wrData[`SCS_BIT_WPROT];
            end
            if (softRst) begin
                cfgL <= '{curSelf: `SCS_RST_CUR_SELF, curBus: `SCS_RST_CUR_BUS,
                          ponTime: `SCS_RST_PON_TIME};
            end else if (wrCfg && regIdx == `SCS_OFF_CUR_SELF) begin
                cfgL.curSelf <= wrData;
            end else if (wrCfg && regIdx == `SCS_OFF_CUR_BUS) begin
                cfgL.curBus <= wrData;
            end else if (wrCfg && regIdx == `SCS_OFF_PON_TIME) begin
                cfgL.ponTime <= wrData;
            end
        end
    end

    // Open drain: only ever pulls low; clock line is never driven
    always_ff @(posedge lclk) begin
        if (lrst) begin
            smbDataOe <= 1'b0;
        end else begin
            smbDataOe <= driveNow;
        end
    end
    assign smbDataOut = 1'b0;

    // -----------------------------------------------------------------
    // System domain: attach crossing and outputs
    // -----------------------------------------------------------------
    logic       attS1, attachClk, attachD;
    logic [1:0] selS1, selS2;
    logic [7:0] stepCnt;
    logic [14:0] cycCnt;
    logic       ponD, ponRun;

    always_ff @(posedge clk) begin
        attS1     <= attachedL;
        attachClk <= attS1;
        selS1     <= {config_select_hi, config_select_lo};
        selS2     <= selS1;
    end

    wire smbModeClk = (selS2 == `SCS_SEL_SMBUS);
    wire stepEnd    = (cycCnt == 15'(PON_STEP_CYCLES - 1));

    // Bytes are frozen once attach is set, so they are safe to take here
    always_ff @(posedge clk) begin
        if (srst) begin
            attachD      <= 1'b0;
            eepromEnable <= 1'b0;
            usbConnect   <= 1'b0;
            cfg          <= '{curSelf: `SCS_RST_CUR_SELF, curBus: `SCS_RST_CUR_BUS,
                              ponTime: `SCS_RST_PON_TIME};
        end else begin
            attachD      <= attachClk;
            eepromEnable <= !smbModeClk;
            usbConnect   <= smbModeClk ? attachClk : 1'b1;
            if (attachClk && !attachD) begin
                cfg <= cfgL;
            end
        end
    end

    // Power-on delay in 2 ms steps
    always_ff @(posedge clk) begin
        if (srst) begin
            ponD          <= 1'b0;
            ponRun        <= 1'b0;
            stepCnt       <= 8'h00;
            cycCnt        <= 15'h0000;
            portPowerGood <= 1'b0;
        end else begin
            ponD <= portPowerOn;
            if (!portPowerOn) begin
                ponRun        <= 1'b0;
                portPowerGood <= 1'b0;
            end else if (!ponD) begin
                ponRun  <= (cfg.ponTime != 8'h00);
                stepCnt <= cfg.ponTime;
                cycCnt  <= 15'h0000;
                portPowerGood <= (cfg.ponTime == 8'h00);
            end else if (ponRun) begin
                cycCnt <= stepEnd ? 15'h0000 : cycCnt + 15'h0001;
                if (stepEnd) begin
                    stepCnt <= stepCnt - 8'h01;
                    if (stepCnt == 8'h01) begin
                        ponRun        <= 1'b0;
                        portPowerGood <= 1'b1;
                    end
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    AST_DRIVE_SLOT: assert property (@(posedge lclk) disable iff (lrst)
        smbDataOe |-> $past(state == ST_ACK || state == ST_SEND)) else $error("Data driven outside slot");
    AST_GEN_CALL: assert property (@(posedge lclk) disable iff (lrst)
        (byteDone && state == ST_RECV && phase == PH_ADDR && rxByte[7:1] == 7'h00 && !stopCond && !startCond)
        |=> !ackNext) else $error("General call acknowledged");
    AST_ADDR_MISS: assert property (@(posedge lclk) disable iff (lrst)
        (byteDone && state == ST_RECV && phase == PH_ADDR && rxByte[7:1] != addrS2 && !stopCond && !startCond)
        |=> !ackNext) else $error("Foreign address acknowledged");
    AST_NACK_IDLE: assert property (@(posedge lclk) disable iff (lrst)
        (state == ST_RECV && sclFall && bitCnt == 4'h8 && !ackNext && !stopCond && !startCond && smbModeL
         && !attachedL) |=> (state == ST_IDLE) ##1 !smbDataOe) else $error("Refused byte not silent");
    AST_REG_HOLD: assert property (@(posedge lclk) disable iff (lrst)
        !commit |=> $stable(cfgL) && $stable(statusReg)) else $error("Register changed without write");
    AST_STOP_IDLE: assert property (@(posedge lclk) disable iff (lrst)
        stopCond |=> state == ST_IDLE ##1 !smbDataOe) else $error("Stop did not idle");
    AST_ATTACH_ONCE: assert property (@(posedge lclk) disable iff (lrst)
        attachedL |=> attachedL [*4]) else $error("Attach bit cleared");
    AST_EXTRA_NACK: assert property (@(posedge lclk) disable iff (lrst)
        (byteDone && state == ST_RECV && phase == PH_EXTRA && !stopCond && !startCond) |=> !ackNext && !wrPend)
        else $error("Extra byte accepted");
    AST_EEPROM_OFF: assert property (@(posedge clk) disable iff (srst)
        smbModeClk && $past(smbModeClk) |-> !eepromEnable) else $error("EEPROM left enabled");
    AST_HOLD_CONNECT: assert property (@(posedge clk) disable iff (srst)
        smbModeClk && !attachClk |=> !usbConnect) else $error("Connect before load done");

    COV_WRITE: cover property (@(posedge lclk) disable iff (lrst) wrCfg);
    COV_READ: cover property (@(posedge lclk) disable iff (lrst) state == ST_SEND ##[1:200] state == ST_MACK);
    COV_ATTACH: cover property (@(posedge clk) disable iff (srst) $rose(usbConnect));
    COV_PGOOD: cover property (@(posedge clk) disable iff (srst) $rose(portPowerGood));
    COV_NACK: cover property (@(posedge lclk) disable iff (lrst) state == ST_RECV && sclFall && bitCnt == 4'h8 && !ackNext);

endmodule

// ==== verif/scs_smbus_host.sv ====
// SMBus host model: bit-banged clock, open-drain data, byte write and byte read.
// Assumes a pull-up on the data wire; the clock is driven only by this model.
`timescale 1ns/1ps

module scs_smbus_host (
    input  wire logic clk,     // Bench clock for bit timing
    input  wire logic sda,     // Resolved data wire level
    output logic      scl,     // Bus clock, idle high
    output logic      sdaLow   // High pulls data low
);
    localparam int Q = 25;

    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    task automatic qwait(input int n);
        repeat (n * Q) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Bus conditions and bits
    // ------------------------------------------------------------
    task automatic start_cond();
        sdaLow = 1'b0;
        qwait(1);
        scl = 1'b1;
        qwait(1);
        sdaLow = 1'b1;
        qwait(1);
        scl = 1'b0;
        qwait(1);
    endtask

    task automatic stop_cond();
        sdaLow = 1'b1;
        qwait(1);
        scl = 1'b1;
        qwait(1);
        sdaLow = 1'b0;
        qwait(2);
    endtask

    // Data only changes while the clock is low
    task automatic hbit(input logic b, output logic seen);
        sdaLow = ~b;
        qwait(1);
        scl = 1'b1;
        qwait(1);
        seen = sda;
        qwait(1);
        scl = 1'b0;
        qwait(1);
    endtask

    // Nine clocks; the ninth slot is released, so a read ends in NACK
    task automatic xbyte(input logic [7:0] v, output logic [7:0] got, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            hbit(v[i], got[i]);
        end
        hbit(1'b1, s);
        ack = ~s;
    endtask

    // ------------------------------------------------------------
    // Transactions
    // ------------------------------------------------------------
    task automatic write_byte(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d,
                              input logic extra, output logic [3:0] acks);
        logic [7:0] g;
        acks = 4'h0;
        start_cond();
        xbyte({a, 1'b0}, g, acks[0]);
        if (acks[0]) begin
            xbyte(idx, g, acks[1]);
        end
        if (acks[1]) begin
            xbyte(d, g, acks[2]);
        end
        if (acks[2] && extra) begin
            xbyte(d, g, acks[3]);
        end
        stop_cond();
    endtask

    task automatic read_byte(input logic [6:0] a, input logic [7:0] idx,
                             output logic [7:0] d, output logic [3:0] acks);
        logic [7:0] g;
        acks = 4'h0;
        d = 8'h00;
        start_cond();
        xbyte({a, 1'b0}, g, acks[0]);
        if (acks[0]) begin
            xbyte(idx, g, acks[1]);
        end
        if (acks[1]) begin
            start_cond();
            xbyte({a, 1'b1}, g, acks[2]);
        end
        if (acks[2]) begin
            xbyte(8'hff, d, acks[3]);
        end
        stop_cond();
    endtask

    task automatic start_stop();
        start_cond();
        stop_cond();
    endtask
endmodule

// ==== verif/smbus_config_slave_tb_top.sv ====
// Testbench for the SMBus configuration slave: register loads, refusals, attach.
// Assumes the host model drives the bus; straps and power-on come from here.
`timescale 1ns/1ps

module smbus_config_slave_tb_top
    import scs_pkg::*;
;
    localparam int         PON  = 20;
    localparam logic [6:0] ADDR = 7'h2c;

    logic       clk = 1'b0;
    logic       lclk = 1'b0;
    logic       srst, scl, hostLow, smbDataOut, smbDataOe, selHi, selLo;
    logic       eepromEnable, usbConnect, portPowerOn, portPowerGood;
    logic [6:0] addrStrap;
    logic [3:0] acks;
    logic [7:0] rdat;
    scs_cfg_s   cfg;
    wire logic  sda;
    int         errors = 0;
    int         num_checks = 0;

    always #50 clk = ~clk;
    initial begin
        #37;
        forever #80 lclk = ~lclk;
    end
    assign sda = ~(hostLow | (smbDataOe & ~smbDataOut));

    scs_smbus_host scs_smbus_host_i (.clk(clk), .sda(sda), .scl(scl), .sdaLow(hostLow));

    scs_smbus_config_slave #(.PON_STEP_CYCLES(PON)) scs_smbus_config_slave_i (
        .clk(clk), .srst(srst), .lclk(lclk), .smbClkIn(scl), .smbDataIn(sda),
        .smbDataOut(smbDataOut), .smbDataOe(smbDataOe), .addrStrap(addrStrap),
        .config_select_hi(selHi), .config_select_lo(selLo), .eepromEnable(eepromEnable),
        .usbConnect(usbConnect), .cfg(cfg), .portPowerOn(portPowerOn), .portPowerGood(portPowerGood));

    // ------------------------------------------------------------
    // Compare and closing
    // ------------------------------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        selHi = 1'b1;
        selLo = 1'b1;
        portPowerOn = 1'b0;
        addrStrap = ADDR;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        repeat (30) @(negedge clk);
        check(24'(cfg), 24'h323232);
        check(24'(usbConnect), 24'h0);
        check(24'(eepromEnable), 24'h0);
        check(24'(smbDataOut), 24'h0);
        scs_smbus_host_i.write_byte(ADDR, 8'h0d, 8'h20, 1'b0, acks);
        check(24'(acks), 24'h7);
        scs_smbus_host_i.read_byte(ADDR, 8'h0d, rdat, acks);
        check(24'(acks), 24'h7);
        check(24'(rdat), 24'h20);
        scs_smbus_host_i.write_byte(ADDR ^ 7'h01, 8'h0d, 8'h11, 1'b0, acks);
        check(24'(acks), 24'h0);
        scs_smbus_host_i.write_byte(7'h00, 8'h0d, 8'h11, 1'b0, acks);
        check(24'(acks), 24'h0);
        scs_smbus_host_i.write_byte(ADDR, 8'h05, 8'h11, 1'b0, acks);
        check(24'(acks), 24'h1);
        scs_smbus_host_i.write_byte(ADDR, 8'h0d, 8'h15, 1'b1, acks);
        check(24'(acks), 24'h7);
        scs_smbus_host_i.read_byte(ADDR, 8'h0d, rdat, acks);
        check(24'(rdat), 24'h20);
        // Soft reset reloads defaults; write protect then freezes the bytes
        scs_smbus_host_i.write_byte(ADDR, 8'h00, 8'h04, 1'b0, acks);
        scs_smbus_host_i.read_byte(ADDR, 8'h0d, rdat, acks);
        check(24'(rdat), 24'h32);
        scs_smbus_host_i.start_stop();
        scs_smbus_host_i.write_byte(ADDR, 8'h0e, 8'h44, 1'b0, acks);
        check(24'(acks), 24'h7);
        scs_smbus_host_i.write_byte(ADDR, 8'h0f, 8'h03, 1'b0, acks);
        scs_smbus_host_i.read_byte(ADDR, 8'h0f, rdat, acks);
        check(24'(rdat), 24'h03);
        scs_smbus_host_i.write_byte(ADDR, 8'h00, 8'h02, 1'b0, acks);
        scs_smbus_host_i.write_byte(ADDR, 8'h0d, 8'h11, 1'b0, acks);
        scs_smbus_host_i.read_byte(ADDR, 8'h0d, rdat, acks);
        check(24'(rdat), 24'h32);
        scs_smbus_host_i.read_byte(ADDR, 8'h00, rdat, acks);
        check(24'(rdat), 24'h02);
        check(24'(usbConnect), 24'h0);
        scs_smbus_host_i.write_byte(ADDR, 8'h00, 8'h01, 1'b0, acks);
        check(24'(acks), 24'h7);
        for (int n = 0; usbConnect !== 1'b1; n++) begin
            if (n == 50) begin
                errors++;
                close_out();
            end
            @(negedge clk);
        end
        check(24'(cfg), 24'h324403);
        scs_smbus_host_i.write_byte(ADDR, 8'h0d, 8'h11, 1'b0, acks);
        check(24'(acks), 24'h0);
        // Three steps of PON cycles before power counts as good
        portPowerOn = 1'b1;
        repeat (3 * PON - 5) @(negedge clk);
        check(24'(portPowerGood), 24'h0);
        repeat (10) @(negedge clk);
        check(24'(portPowerGood), 24'h1);
        portPowerOn = 1'b0;
        repeat (3) @(negedge clk);
        check(24'(portPowerGood), 24'h0);
        selLo = 1'b0;
        repeat (10) @(negedge clk);
        check(24'(eepromEnable), 24'h1);
        check(24'(usbConnect), 24'h1);
        close_out();
    end
endmodule
